/* File: verification/nvm_access_chk.sv */
`timescale 1ns/1ps
module nvm_access_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [nvm_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic stack_full,
	input wire logic irq_ack,
	input wire logic irq_request
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_aw_once; awvalid && awready |=> !awready; endproperty
	a_aw_once: assert property (p_aw_once) else $error("second address taken");
	property p_ar_rv; arvalid && arready |=> rvalid && !arready; endproperty
	a_ar_rv: assert property (p_ar_rv) else $error("read answer late");
	property p_r_done; rvalid && rready |=> !rvalid; endproperty
	a_r_done: assert property (p_r_done) else $error("read answer repeated");
	property p_rdata_top; rvalid |-> rdata[31:8] == 24'h0; endproperty
	a_rdata_top: assert property (p_rdata_top) else $error("upper bits set");
	property p_ctrl_top;
		arvalid && arready && (araddr == nvm_pkg::OFS_CONTROL) |=> rdata[31:4] == 28'h0;
	endproperty
	a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");
	property p_stack; stack_full |=> !irq_request; endproperty
	a_stack: assert property (p_stack) else $error("request with stack full");
	property p_ack; irq_ack |=> !irq_request ##1 !irq_request; endproperty
	a_ack: assert property (p_ack) else $error("request after service");
endmodule

bind nvm_access nvm_access_chk chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .araddr(araddr), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.stack_full(stack_full), .irq_ack(irq_ack), .irq_request(irq_request));

/* File: verification/nvm_core_model.sv */
`timescale 1ns/1ps
module nvm_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq_request,
	input wire logic stack_busy,
	input wire logic [3:0] ack_delay,
	output logic stack_full,
	output logic irq_ack
);
	logic [3:0] wait_cnt;

	// core services the request after ack_delay+1 cycles
	assign stack_full = stack_busy;
	always_ff @(posedge aclk) begin
		if (!aresetn || !irq_request || irq_ack) begin
			wait_cnt <= 4'h0;
			irq_ack <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
			irq_ack <= (wait_cnt == ack_delay);
		end
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
	import nvm_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, stack_busy = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, v;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [3:0] wstrb = 4'hF, ack_delay = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, stack_full, irq_ack, irq_request;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] mem [64];
	logic [5:0] a;
	logic [7:0] d;
	int n_mismatch = 0, comparisons = 0, n_ack = 0, acks = 0, i;

	nvm_access #(.WRITE_PRESCALE_P(2), .WRITE_TICKS_P(16)) dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .stack_full(stack_full), .irq_ack(irq_ack),
		.irq_request(irq_request));
	nvm_core_model core (.aclk(aclk), .aresetn(aresetn), .irq_request(irq_request),
		.stack_busy(stack_busy), .ack_delay(ack_delay), .stack_full(stack_full),
		.irq_ack(irq_ack));

	initial begin
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (irq_ack === 1'b1) n_ack++;
	end

	// ------------------------------
	// checking and bus tasks
	// ------------------------------
	function automatic logic [1:0] resp_for(input logic [7:0] ad);
		return (ad <= OFS_IRQ) ? RESP_OKAY : RESP_SLVERR;
	endfunction
	function automatic logic [31:0] irq_exp(input bit en, input bit flag);
		return {29'h0, flag, en, en};
	endfunction
	task automatic conclude();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic guard(input bit bad);
		if (bad) begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		int k;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			k++;
		end while (!bvalid && k < 60);
		bready <= 1'b0;
		guard(k >= 60);
		check(32'(bresp), 32'(resp_for(ad)));
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input bit cmp = 1'b1);
		int k;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			k++;
		end while (!rvalid && k < 60);
		rready <= 1'b0;
		v = rdata;
		guard(k >= 60);
		check(32'(rresp), 32'(resp_for(ad)));
		if (cmp) check(v, ex);
	endtask
	task automatic poll(input logic [7:0] ad, input logic [31:0] m);
		int k;
		v = m;
		for (k = 0; k < 100 && (v & m) != 32'h0; k++) rd(ad, 32'h0, 1'b0);
		guard((v & m) != 32'h0);
	endtask

	initial begin
		i = $urandom(32'h47F1);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 4; i++) rd(8'(i * 4), 32'h0);
		wr(OFS_ADDRESS, 32'hFFFFFFFF);
		rd(OFS_ADDRESS, 32'h3F);
		wr(8'h10, 32'h1);
		rd(8'h10, 32'h0);
		for (i = 0; i < 6; i++) begin
			a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
			d = 8'($urandom);
			stack_busy <= (i == 3);
			ack_delay <= 4'($urandom_range(7, 0));
			wr(OFS_IRQ, 32'(i[0]));
			wr(OFS_ADDRESS, 32'(a));
			wr(OFS_DATA, 32'(d));
			wr(OFS_CONTROL, 32'h4);
			rd(OFS_CONTROL, 32'h0);
			wr(OFS_CONTROL, 32'h8);
			wr(OFS_CONTROL, 32'hC);
			wr(OFS_IRQ, irq_exp(i[0], 1'b0));
			wr(OFS_CONTROL, 32'hA);
			wr(OFS_CONTROL, 32'hB);
			rd(OFS_CONTROL, 32'hE);
			poll(OFS_CONTROL, 32'h4);
			mem[a] = d;
			if (i == 3) begin
				rd(OFS_IRQ, irq_exp(1'b1, 1'b1));
				stack_busy <= 1'b0;
			end
			if (i[0]) begin
				poll(OFS_IRQ, 32'h4);
				acks++;
				check(32'(n_ack), 32'(acks));
			end else begin
				rd(OFS_IRQ, irq_exp(1'b0, 1'b1));
				wr(OFS_IRQ, 32'h4);
			end
			wr(OFS_DATA, 32'(~d));
			wr(OFS_CONTROL, 32'h1);
			rd(OFS_CONTROL, 32'h0);
			wr(OFS_CONTROL, 32'h2);
			wr(OFS_CONTROL, 32'h3);
			poll(OFS_CONTROL, 32'h1);
			rd(OFS_DATA, 32'(mem[a]));
			wr(OFS_ADDRESS, 32'(~a));
			rd(OFS_DATA, 32'(mem[a]));
		end
		wr(OFS_CONTROL, 32'h8);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_CONTROL, 32'h0);
		conclude();
	end
endmodule

/* File: verilog/nvm_access.sv */
`timescale 1ns/1ps
module nvm_access #(
	parameter int WRITE_PRESCALE_P = nvm_pkg::WRITE_PRESCALE,
	parameter int WRITE_TICKS_P = nvm_pkg::WRITE_TICKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [nvm_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [nvm_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic stack_full,
	input wire logic irq_ack,
	output logic irq_request
);
	import nvm_pkg::*;

	// -------------------------------------------------------------
	// address decode
	// -------------------------------------------------------------
	function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a);
		is_mapped = (a == OFS_ADDRESS) || (a == OFS_DATA) ||
			(a == OFS_CONTROL) || (a == OFS_IRQ);
	endfunction

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	localparam int RCW = $clog2(READ_CYCLES);
	localparam logic [RCW-1:0] READ_LAST = RCW'(READ_CYCLES - 1);

	nvm_ctrl_s ctrl;
	nvm_ctrl_s wctrl;
	nvm_state_e state;
	logic [NVM_ADDR_W-1:0] address_reg;
	logic [NVM_DATA_W-1:0] data_reg;
	logic [NVM_ADDR_W-1:0] lat_addr;
	logic [NVM_DATA_W-1:0] lat_data;
	logic [NVM_DATA_W-1:0] mem_rdata;
	logic [RCW-1:0] read_cnt;
	logic irq_enable;
	logic global_irq_enable;
	logic irq_flag;

	logic aw_got;
	logic w_got;
	logic [AXI_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic wr_ctrl;
	logic wr_addr_reg;
	logic wr_data_reg;
	logic wr_irq;
	logic start_store;
	logic start_fetch;
	logic write_end;
	logic read_end;

	// -------------------------------------------------------------
	// write channel capture
	// -------------------------------------------------------------
	assign do_write = aw_got && w_got && !bvalid;
	assign wr_ctrl = do_write && (aw_addr_q == OFS_CONTROL) && w_strb_q[0];
	assign wr_addr_reg = do_write && (aw_addr_q == OFS_ADDRESS) && w_strb_q[0];
	assign wr_data_reg = do_write && (aw_addr_q == OFS_DATA) && w_strb_q[0];
	assign wr_irq = do_write && (aw_addr_q == OFS_IRQ) && w_strb_q[0];
	assign wctrl = nvm_ctrl_s'(w_data_q[CTRL_W-1:0]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			aw_got <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_got <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid && wready) begin
			w_got <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			w_got <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
		end else if (!aw_got && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
		end else if (!w_got && !bvalid) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// read channel
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (araddr)
				OFS_ADDRESS: rdata <= {26'h0, address_reg}; // see [R19]
				OFS_DATA: rdata <= {24'h0, data_reg};
				OFS_CONTROL: rdata <= {28'h0, ctrl}; // see [R9]
				OFS_IRQ: rdata <= {29'h0, irq_flag, global_irq_enable, irq_enable};
				default: rdata <= '0;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// start decisions
	// -------------------------------------------------------------
	// go accepted only if enable was already set before this write
	assign start_store = wr_ctrl && wctrl.store_go && !wctrl.fetch_go
		&& ctrl.store_enable && (state == ST_IDLE); // see [R1] see [R2] see [R4] see [R21]
	assign start_fetch = wr_ctrl && wctrl.fetch_go && !wctrl.store_go
		&& ctrl.fetch_enable && (state == ST_IDLE); // see [R5] see [R7] see [R21]
	assign read_end = (state == ST_READ) && (read_cnt == READ_LAST);

	// -------------------------------------------------------------
	// control register
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= nvm_ctrl_s'(RST_CONTROL); // see [R15]
		end else begin
			if (wr_ctrl) begin
				ctrl.store_enable <= wctrl.store_enable;
				ctrl.fetch_enable <= wctrl.fetch_enable;
			end
			if (start_store) begin
				ctrl.store_go <= 1'b1;
			end else if (write_end) begin
				ctrl.store_go <= 1'b0; // see [R3]
			end
			if (start_fetch) begin
				ctrl.fetch_go <= 1'b1; // see [R6]
			end else if (read_end) begin
				ctrl.fetch_go <= 1'b0; // see [R6]
			end
		end
	end

	// -------------------------------------------------------------
	// cycle sequencer
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_store) begin
						state <= ST_WRITE;
					end else if (start_fetch) begin
						state <= ST_READ;
					end
				end
				ST_READ: begin
					if (read_end) begin
						state <= ST_IDLE;
					end
				end
				ST_WRITE: begin
					if (write_end) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			read_cnt <= '0;
		end else if (start_fetch) begin
			read_cnt <= '0;
		end else if (state == ST_READ) begin
			read_cnt <= read_cnt + RCW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lat_addr <= RST_ADDRESS;
			lat_data <= RST_DATA;
		end else if (start_store) begin
			lat_addr <= address_reg; // see [R2]
			lat_data <= data_reg;
		end
	end

	// -------------------------------------------------------------
	// address and data registers
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			address_reg <= RST_ADDRESS;
		end else if (wr_addr_reg) begin
			address_reg <= w_data_q[NVM_ADDR_W-1:0]; // see [R19]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_reg <= RST_DATA;
		end else if (read_end) begin
			data_reg <= mem_rdata; // see [R10] see [R11]
		end else if (wr_data_reg) begin
			data_reg <= w_data_q[NVM_DATA_W-1:0];
		end
	end

	// -------------------------------------------------------------
	// interrupt flag and request
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable <= 1'b0;
			global_irq_enable <= 1'b0;
		end else if (wr_irq) begin
			irq_enable <= w_data_q[IRQ_ENABLE_BIT];
			global_irq_enable <= w_data_q[IRQ_GLOBAL_BIT];
		end
	end

	// set wins over service or write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag <= 1'b0;
		end else if (write_end) begin
			irq_flag <= 1'b1; // see [R16]
		end else if (irq_ack || (wr_irq && w_data_q[IRQ_FLAG_BIT])) begin
			irq_flag <= 1'b0; // see [R18]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= irq_flag && irq_enable && global_irq_enable
				&& !stack_full && !irq_ack; // see [R17]
		end
	end

	// -------------------------------------------------------------
	// storage and write timing
	// -------------------------------------------------------------
	nvm_write_timer #(
		.PRESCALE(WRITE_PRESCALE_P),
		.TICKS(WRITE_TICKS_P)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start_store),
		.done(write_end) // see [R14]
	);

	nvm_array #(
		.DEPTH(NVM_DEPTH),
		.AW(NVM_ADDR_W),
		.DW(NVM_DATA_W)
	) u_array (
		.aclk(aclk),
		.wr_en(write_end),
		.wr_addr(lat_addr),
		.wr_data(lat_data),
		.rd_en(start_fetch),
		.rd_addr(address_reg),
		.rd_data(mem_rdata)
	);
endmodule

/* File: verilog/nvm_array.sv */
`timescale 1ns/1ps
module nvm_array #(
	parameter int DEPTH = 64,
	parameter int AW = 6,
	parameter int DW = 8
) (
	input wire logic aclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] cells [DEPTH];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule

/* File: verilog/nvm_pkg.sv */
// Behaviour
// [R1] store_enable set before any write
// [R2] store_go with store_enable starts write
// [R3] store_go clears itself at write end
// [R4] store_go without store_enable does nothing
// [R5] fetch_enable needed for reads; clear blocks
// [R6] fetch_go with fetch_enable starts read, clears
// [R7] fetch_go without fetch_enable does nothing
// [R8] software never sets both go bits
// [R9] control bits 7 to 4 read zero
// [R10] address before read; byte in data
// [R11] fetched byte holds until next operation
// [R12] software enables, then sets store_go next
// [R13] software masks global interrupts around start
// [R14] write time from free-running internal timer
// [R15] power-on reset clears store_enable
// [R16] write end sets nvm_irq_flag always
// [R17] request needs both enables, stack not full
// [R18] servicing interrupt clears nvm_irq_flag
// [R19] 64 bytes, six address bits, rest zero
// [R20] software avoids sleep during cycles
// [R21] start requests ignored while cycle runs
package nvm_pkg;

	localparam int AXI_ADDR_W = 8;
	localparam int NVM_DEPTH = 64;
	localparam int NVM_ADDR_W = 6;
	localparam int NVM_DATA_W = 8;

	// -------------------------------------------------------------
	// register byte addresses
	// -------------------------------------------------------------
	localparam logic [7:0] OFS_ADDRESS = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_IRQ = 8'h0C;

	// -------------------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------------------
	localparam int CTRL_W = 4;
	localparam int IRQ_ENABLE_BIT = 0;
	localparam int IRQ_GLOBAL_BIT = 1;
	localparam int IRQ_FLAG_BIT = 2;
	localparam logic [3:0] RST_CONTROL = 4'h0;
	localparam logic [5:0] RST_ADDRESS = 6'h00;
	localparam logic [7:0] RST_DATA = 8'h00;

	// -------------------------------------------------------------
	// cycle counts
	// -------------------------------------------------------------
	localparam int READ_CYCLES = 2;
	localparam int WRITE_PRESCALE = 16;
	localparam int WRITE_TICKS = 32;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic store_enable;
		logic store_go;
		logic fetch_enable;
		logic fetch_go;
	} nvm_ctrl_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_WRITE = 2'h2
	} nvm_state_e;

endpackage

/* File: verilog/nvm_write_timer.sv */
`timescale 1ns/1ps
module nvm_write_timer #(
	parameter int PRESCALE = 16,
	parameter int TICKS = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	output logic done
);
	localparam int PW = $clog2(PRESCALE);
	localparam int TW = $clog2(TICKS);
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICKS - 1);

	logic [PW-1:0] pre;
	logic [TW-1:0] count;
	logic busy;
	logic tick;

	// free-running base, so start phase varies (see [R14])
	assign tick = (pre == PRE_LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre <= '0;
		end else if (tick) begin
			pre <= '0;
		end else begin
			pre <= pre + PW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			count <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				count <= '0;
			end else if (busy && tick) begin
				if (count == TICK_LAST) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count + TW'(1);
				end
			end
		end
	end
endmodule
